// ### hdl/ctrl_end.sv
// controller end: timed start-up and braking sequence, avalon slave
`timescale 1ns/1ns
// Notes on behaviour
// - reset pulse longer than 20 ms
// - no motor power without power enable
// - command zero while command enable low
// - fault-free contact only without fault
// - fault-free status drives mains contactor
// - at most 62 drives per link
// - wait 3 s after logic supply
// - hold reset at least 100 ms
// - allow 1 s boot after reset
// - 3 s soft-start before readiness
// - 100 ms to acquire fault-free status
// - 100 ms from power to command enable
// - reset only first start or fault
// - fault-free needs line; enable at once
// - braking starts by dropping command enable
// - power enable off 100 ms later
// - mains off 15 ms after power off
// - holding brake only at standstill
module ctrl_end #(
    parameter int unsigned LOGIC_WAIT = servo_seq_pkg::LOGIC_WAIT_CYC,
    parameter int unsigned RESET_HOLD = servo_seq_pkg::RESET_HOLD_CYC,
    parameter int unsigned BOOT_WAIT = servo_seq_pkg::BOOT_WAIT_CYC,
    parameter int unsigned SOFTSTART = servo_seq_pkg::SOFTSTART_CYC,
    parameter int unsigned OK_ACQ = servo_seq_pkg::OK_ACQ_CYC,
    parameter int unsigned TORQUE = servo_seq_pkg::TORQUE_CYC,
    parameter int unsigned BRAKE = servo_seq_pkg::BRAKE_CYC,
    parameter int unsigned MAINS_OFF = servo_seq_pkg::MAINS_OFF_CYC
) (
    input wire logic clk_sys,
    input wire logic rstn,
    drive_ctl_if.ctrl link,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic standstill,
    output logic hold_brake,
    output logic irq
);
    // ***************************************************
    // state
    // ***************************************************
    typedef enum {
        ST_LOGIC, ST_RESET, ST_BOOT, ST_IDLE, ST_SOFT, ST_ACQ,
        ST_TORQUE, ST_RUN, ST_BRAKE, ST_MAINS, ST_FAULT
    } seq_t;
    localparam int EW = servo_seq_pkg::EV_W;
    typedef struct packed {
        seq_t st;
        logic [31:0] cnt;
        logic [2:0] ok_s;
        logic first_done;
        logic rst_o;
        logic pen_o;
        logic cen_o;
        logic line_o;
        logic brake;
        logic ack;
        logic [31:0] rdata;
        logic [EW-1:0] ev;
        logic [EW-1:0] mask;
        logic [7:0] drops;
        logic start_req;
        logic stop_req;
    } cstate_t;
    cstate_t s_q, s_d;

    logic ok;
    logic req;
    logic done;
    logic [EW-1:0] ev_set;
    logic wr_go;

    assign ok = s_q.ok_s[2];
    assign req = (avs_read || avs_write) && !s_q.ack;
    // writes land only at the edge that sees waitrequest low
    assign wr_go = avs_write && s_q.ack;
    // count strictly past the minimum
    assign done = s_q.cnt == 32'h0;

    always_comb begin
        s_d = s_q;
        ev_set = '0;
        s_d.ok_s = {s_q.ok_s[1:0], link.fault_free};
        if (s_q.cnt != 32'h0) begin
            s_d.cnt = s_q.cnt - 32'h1;
        end
        // ***************************************************
        // register slave
        // ***************************************************
        s_d.ack = req;
        if (wr_go) begin
            case (avs_address)
                servo_seq_pkg::ADR_CTRL: begin
                    // start outside idle or fault is refused outright
                    if (avs_writedata[servo_seq_pkg::CTRL_START]
                        && (s_q.st == ST_IDLE || s_q.st == ST_FAULT)) begin
                        s_d.start_req = 1'b1;
                    end
                    if (avs_writedata[servo_seq_pkg::CTRL_STOP]) begin
                        s_d.stop_req = 1'b1;
                    end
                    s_d.drops = avs_writedata[servo_seq_pkg::CTRL_DROPS_LSB
                        +: 8];
                end
                servo_seq_pkg::ADR_IRQ: begin
                    s_d.ev = s_q.ev & ~avs_writedata[EW-1:0];
                end
                servo_seq_pkg::ADR_MASK: s_d.mask = avs_writedata[EW-1:0];
                default: ;
            endcase
        end
        if (req && avs_read) begin
            case (avs_address)
                servo_seq_pkg::ADR_CTRL: s_d.rdata = {16'h0, s_q.drops, 8'h0};
                servo_seq_pkg::ADR_STAT: s_d.rdata = {20'h0, 4'(s_q.st), 3'h0,
                    s_q.line_o, s_q.cen_o, s_q.pen_o, s_q.rst_o, ok};
                servo_seq_pkg::ADR_IRQ: s_d.rdata = {29'h0, s_q.ev};
                servo_seq_pkg::ADR_MASK: s_d.rdata = {29'h0, s_q.mask};
                default: s_d.rdata = servo_seq_pkg::UNMAPPED_RD;
            endcase
        end
        // ***************************************************
        // sequence
        // ***************************************************
        case (s_q.st)
            ST_LOGIC: if (done) begin
                s_d.st = ST_RESET;
                s_d.rst_o = 1'b1;
                s_d.cnt = RESET_HOLD;
            end
            ST_RESET: if (done) begin
                s_d.rst_o = 1'b0;
                s_d.first_done = 1'b1;
                s_d.st = ST_BOOT;
                s_d.cnt = BOOT_WAIT;
            end
            ST_BOOT: if (done) begin
                s_d.st = ST_IDLE;
            end
            ST_IDLE: if (s_q.start_req) begin
                // a refused start is dropped, not kept for later
                s_d.start_req = 1'b0;
                if (s_q.drops
                    <= 8'(servo_seq_pkg::MAX_DROPS)) begin
                    s_d.line_o = 1'b1;
                    s_d.brake = 1'b0;
                    s_d.st = ST_SOFT;
                    s_d.cnt = SOFTSTART;
                end
            end
            ST_SOFT: if (done) begin
                s_d.st = ST_ACQ;
                s_d.cnt = OK_ACQ;
            end
            ST_ACQ: if (done && ok) begin
                s_d.pen_o = 1'b1;
                s_d.st = ST_TORQUE;
                s_d.cnt = TORQUE;
            end
            ST_TORQUE: if (done) begin
                s_d.cen_o = 1'b1;
                s_d.st = ST_RUN;
                ev_set[servo_seq_pkg::EV_READY] = 1'b1;
            end
            ST_RUN: if (s_q.stop_req) begin
                s_d.stop_req = 1'b0;
                s_d.cen_o = 1'b0;
                s_d.st = ST_BRAKE;
                s_d.cnt = BRAKE;
            end
            ST_BRAKE: if (done) begin
                s_d.pen_o = 1'b0;
                s_d.st = ST_MAINS;
                s_d.cnt = MAINS_OFF;
            end
            ST_MAINS: if (done) begin
                s_d.line_o = 1'b0;
                s_d.st = ST_IDLE;
                ev_set[servo_seq_pkg::EV_STOPPED] = 1'b1;
            end
            ST_FAULT: if (s_q.start_req) begin
                s_d.start_req = 1'b0;
                s_d.rst_o = 1'b1;
                s_d.st = ST_RESET;
                s_d.cnt = RESET_HOLD;
            end
            default: s_d.st = ST_LOGIC;
        endcase
        // fault in torque, run or brake opens the contactor at once, no braking possible
        if (!ok && (s_q.st == ST_TORQUE || s_q.st == ST_RUN
            || s_q.st == ST_BRAKE)) begin
            s_d.line_o = 1'b0;
            s_d.pen_o = 1'b0;
            s_d.cen_o = 1'b0;
            s_d.st = ST_FAULT;
            ev_set[servo_seq_pkg::EV_FAULT] = 1'b1;
        end
        if (s_q.st == ST_IDLE && !s_q.line_o && standstill) begin
            s_d.brake = 1'b1;
        end
        s_d.ev = s_d.ev | ev_set;
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.st <= ST_LOGIC;
            s_q.cnt <= LOGIC_WAIT;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.reset_pulse = s_q.rst_o;
    assign link.power_en = s_q.pen_o;
    assign link.cmd_en = s_q.cen_o;
    assign link.line_on = s_q.line_o;
    assign avs_readdata = s_q.rdata;
    assign avs_waitrequest = !s_q.ack;
    assign hold_brake = s_q.brake;
    assign irq = |(s_q.ev & s_q.mask);
endmodule : ctrl_end

// ### hdl/drive_ctl_if.sv
// discrete handshake wires between drive and machine controller
`timescale 1ns/1ns
interface drive_ctl_if;
    logic reset_pulse;
    logic power_en;
    logic cmd_en;
    logic fault_free;
    logic line_on;
    modport drive (input reset_pulse, input power_en, input cmd_en,
        input line_on, output fault_free);
    modport ctrl (output reset_pulse, output power_en, output cmd_en,
        output line_on, input fault_free);
endinterface : drive_ctl_if

// ### hdl/drive_end.sv
// drive end: reset filter, enable gating and fault-free contact
`timescale 1ns/1ns
module drive_end #(
    parameter int unsigned RESET_MIN = servo_seq_pkg::RESET_MIN_CYC,
    parameter int unsigned SOFTSTART = servo_seq_pkg::SOFTSTART_CYC,
    parameter int CMD_W = servo_seq_pkg::CMD_W
) (
    input wire logic clk_sys,
    input wire logic rstn,
    drive_ctl_if.drive link,
    input wire logic [CMD_W-1:0] cmd_ref,
    input wire logic fault_in,
    output logic [CMD_W-1:0] motor_cmd,
    output logic power_on,
    output logic reinit
);
    // ***************************************************
    // state
    // ***************************************************
    typedef struct packed {
        logic [2:0] rst_s;
        logic [2:0] pen_s;
        logic [2:0] cen_s;
        logic [2:0] line_s;
        logic [31:0] rst_cnt;
        logic [31:0] ss_cnt;
        logic fault;
        logic reinit;
        logic ok;
        logic pwr;
        logic [CMD_W-1:0] cmd;
    } dstate_t;
    dstate_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        // three-flop synchronisers, bit 2 is the usable copy
        s_d.rst_s = {s_q.rst_s[1:0], link.reset_pulse};
        s_d.pen_s = {s_q.pen_s[1:0], link.power_en};
        s_d.cen_s = {s_q.cen_s[1:0], link.cmd_en};
        s_d.line_s = {s_q.line_s[1:0], link.line_on};
        s_d.reinit = 1'b0;
        // short glitches never re-initialise
        if (s_q.rst_s[2]) begin
            if (s_q.rst_cnt < RESET_MIN) begin
                s_d.rst_cnt = s_q.rst_cnt + 32'h1;
            end
        end else begin
            s_d.rst_cnt = 32'h0;
            if (s_q.rst_cnt >= RESET_MIN) begin
                s_d.reinit = 1'b1;
                s_d.fault = 1'b0;
            end
        end
        if (fault_in) begin
            s_d.fault = 1'b1;
        end
        if (!s_q.line_s[2]) begin
            s_d.ss_cnt = 32'h0;
        end else if (s_q.ss_cnt < SOFTSTART) begin
            s_d.ss_cnt = s_q.ss_cnt + 32'h1;
        end
        s_d.ok = !s_d.fault && s_q.line_s[2]
            && s_q.ss_cnt >= SOFTSTART;
        s_d.pwr = s_q.pen_s[2] && !s_q.fault;
        s_d.cmd = (s_q.cen_s[2] && s_q.pwr) ? cmd_ref : '0;
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.fault_free = s_q.ok;
    assign motor_cmd = s_q.cmd;
    assign power_on = s_q.pwr;
    assign reinit = s_q.reinit;
endmodule : drive_end

// ### hdl/servo_seq_pkg.sv
// shared constants for the servo drive enable sequencer
package servo_seq_pkg;
    localparam int unsigned CLK_HZ = 10000000;
    localparam int unsigned RESET_MIN_MS = 20;
    localparam int unsigned RESET_MIN_CYC = RESET_MIN_MS * (CLK_HZ / 1000) + 1;
    localparam int unsigned LOGIC_WAIT_MS = 3000;
    localparam int unsigned LOGIC_WAIT_CYC = LOGIC_WAIT_MS * (CLK_HZ / 1000);
    localparam int unsigned RESET_HOLD_MS = 100;
    localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_MS * (CLK_HZ / 1000);
    localparam int unsigned BOOT_WAIT_MS = 1000;
    localparam int unsigned BOOT_WAIT_CYC = BOOT_WAIT_MS * (CLK_HZ / 1000);
    localparam int unsigned SOFTSTART_MS = 3000;
    localparam int unsigned SOFTSTART_CYC = SOFTSTART_MS * (CLK_HZ / 1000);
    localparam int unsigned OK_ACQ_MS = 100;
    localparam int unsigned OK_ACQ_CYC = OK_ACQ_MS * (CLK_HZ / 1000);
    localparam int unsigned TORQUE_MS = 100;
    localparam int unsigned TORQUE_CYC = TORQUE_MS * (CLK_HZ / 1000);
    localparam int unsigned BRAKE_MS = 100;
    localparam int unsigned BRAKE_CYC = BRAKE_MS * (CLK_HZ / 1000);
    localparam int unsigned MAINS_OFF_MS = 15;
    localparam int unsigned MAINS_OFF_CYC = MAINS_OFF_MS * (CLK_HZ / 1000);
    localparam int unsigned MAX_DROPS = 62;
    localparam int CMD_W = 16;
    // controller registers, word offsets as byte addresses
    localparam logic [3:0] ADR_CTRL = 4'h0;
    localparam logic [3:0] ADR_STAT = 4'h4;
    localparam logic [3:0] ADR_IRQ = 4'h8;
    localparam logic [3:0] ADR_MASK = 4'hc;
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_CLEAR = 2;
    localparam int CTRL_DROPS_LSB = 8;
    localparam int EV_READY = 0;
    localparam int EV_FAULT = 1;
    localparam int EV_STOPPED = 2;
    localparam int EV_W = 3;
    localparam logic [31:0] UNMAPPED_RD = 32'hdead_0000;
endpackage : servo_seq_pkg

// ### tb/seq_checker.sv
// interface checker for the drive enable handshake
`timescale 1ns/1ns
module seq_checker #(
    parameter int LOGIC_WAIT = 20,
    parameter int RESET_HOLD = 40,
    parameter int SOFTSTART = 30,
    parameter int OK_ACQ = 20,
    parameter int TORQUE = 20,
    parameter int BRAKE = 20,
    parameter int MAINS_OFF = 15
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic reset_pulse,
    input wire logic power_en,
    input wire logic cmd_en,
    input wire logic fault_free,
    input wire logic line_on
);
    // ****************
    // interval counters
    // ****************
    int up_q, rp_q, ln_q, pe_q, ce_q, pd_q;
    always_ff @(posedge clk_sys) begin
        up_q <= !rstn ? 0 : up_q + 1;
        rp_q <= (!rstn || !reset_pulse) ? 0 : rp_q + 1;
        ln_q <= (!rstn || !line_on) ? 0 : ln_q + 1;
        pe_q <= (!rstn || !power_en) ? 0 : pe_q + 1;
        ce_q <= (!rstn || cmd_en) ? 0 : ce_q + 1;
        pd_q <= (!rstn || power_en) ? 0 : pd_q + 1;
    end
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    AST_RESET_HOLD: assert property (
        $fell(reset_pulse) |-> rp_q >= RESET_HOLD)
        else $error("reset pulse too short");
    AST_RESET_WHEN: assert property (
        $rose(reset_pulse) |-> up_q >= LOGIC_WAIT && !power_en && !line_on)
        else $error("reset pulse at wrong time");
    AST_CMD_NEEDS_PWR: assert property (
        cmd_en |-> power_en && line_on)
        else $error("command enable without power");
    AST_TORQUE_WAIT: assert property (
        $rose(cmd_en) |-> pe_q >= TORQUE)
        else $error("command enable too early");
    AST_PWR_START: assert property (
        $rose(power_en) |-> fault_free && ln_q >= SOFTSTART + OK_ACQ)
        else $error("power enable too early");
    AST_OK_RISE: assert property (
        $rose(fault_free) |-> line_on && ln_q >= SOFTSTART)
        else $error("fault free too early");
    AST_OK_DROP: assert property (
        $fell(line_on) |-> ##[0:8] !fault_free)
        else $error("fault free kept without line");
    AST_BRAKE_WAIT: assert property (
        $fell(power_en) && fault_free |-> !cmd_en && ce_q >= BRAKE)
        else $error("power off too early");
    AST_MAINS_OFF: assert property (
        $fell(line_on) && fault_free |->
        pd_q >= MAINS_OFF && pd_q <= MAINS_OFF + 3)
        else $error("mains off at wrong time");
    AST_FAULT_OFF: assert property (
        $fell(fault_free) && power_en |->
        ##[0:4] !power_en && !cmd_en && !line_on)
        else $error("fault did not remove power");
    cover property ($rose(cmd_en));
    cover property ($fell(line_on) && fault_free);
    cover property ($fell(fault_free) && power_en);
endmodule : seq_checker

// ### tb/servo_drive_enable_sequencer_test.sv
// bench for both ends of the drive enable handshake
`timescale 1ns/1ns
module servo_drive_enable_sequencer_test;
    // short counts keep the run brief; reset min stays below hold
    localparam int unsigned LW = 20, RH = 40, BW = 20, SS = 30, OA = 20;
    localparam logic [3:0] C_CTRL = servo_seq_pkg::ADR_CTRL;
    localparam logic [3:0] C_STAT = servo_seq_pkg::ADR_STAT;
    localparam logic [3:0] C_IRQ = servo_seq_pkg::ADR_IRQ;
    localparam logic [3:0] C_MASK = servo_seq_pkg::ADR_MASK;
    logic clk_sys, rstn, avs_read, avs_write, avs_waitrequest, irq;
    logic standstill, fault_in, hold_brake, power_on, reinit;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [15:0] cmd_ref, motor_cmd;
    int err_total, compares, reinits, n;
    drive_ctl_if link();
    ctrl_end #(.LOGIC_WAIT(LW), .RESET_HOLD(RH), .BOOT_WAIT(BW),
        .SOFTSTART(SS), .OK_ACQ(OA), .TORQUE(20), .BRAKE(20),
        .MAINS_OFF(15)) i_ctrl_end (.clk_sys, .rstn, .link, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .standstill, .hold_brake, .irq);
    drive_end #(.RESET_MIN(25), .SOFTSTART(SS)) i_drive_end (.clk_sys,
        .rstn, .link, .cmd_ref, .fault_in, .motor_cmd, .power_on, .reinit);
    seq_checker #(.LOGIC_WAIT(LW), .RESET_HOLD(RH), .SOFTSTART(SS),
        .OK_ACQ(OA)) i_seq_checker (.clk_sys, .rstn,
        .reset_pulse(link.reset_pulse), .power_en(link.power_en),
        .cmd_en(link.cmd_en), .fault_free(link.fault_free),
        .line_on(link.line_on));
    // ****************
    // tasks
    // ****************
    task automatic chk(input string s, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        // hold until the edge that samples waitrequest low
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic poll(input logic [3:0] a, input int b);
        do bus(1'b0, a, 32'h0); while (q[b] !== 1'b1);
    endtask : poll
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    // ****************
    // stimulus
    // ****************
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (reinit === 1'b1) reinits++;
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        $display("mismatch watchdog expected done seen hang");
        tally_and_finish();
    end
    initial begin
        {rstn, avs_read, avs_write, standstill, fault_in} = 5'h0;
        {avs_address, avs_writedata, cmd_ref} = 52'h0;
        cmd_ref = 16'h1234;
        {err_total, compares, reinits} = 0;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (LW + RH + BW + 20) @(posedge clk_sys);
        chk("reinit", 1, reinits);
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped", servo_seq_pkg::UNMAPPED_RD, q);
        bus(1'b1, C_CTRL, 32'h3f01);
        repeat (20) @(posedge clk_sys);
        bus(1'b0, C_STAT, 32'h0);
        chk("line too many drops", 0, q[4]);
        $display("test power-up done");
        bus(1'b1, C_MASK, 32'h0);
        bus(1'b1, C_CTRL, 32'h3e01);
        bus(1'b0, C_CTRL, 32'h0);
        chk("drops", 32'h3e00, q);
        poll(C_STAT, 3);
        // the drive's input sync delays the command by a few cycles
        repeat (8) @(posedge clk_sys);
        chk("irq masked", 0, irq);
        chk("power", 1, power_on);
        chk("motor cmd", 16'h1234, motor_cmd);
        chk("brake", 0, hold_brake);
        bus(1'b1, C_MASK, 32'h7);
        bus(1'b0, C_MASK, 32'h0);
        chk("mask", 32'h7, q);
        chk("irq ready", 1, irq);
        bus(1'b1, C_IRQ, 32'h1);
        @(posedge clk_sys);
        chk("irq cleared", 0, irq);
        $display("test start done");
        standstill <= 1'b1;
        bus(1'b1, C_CTRL, 32'h2);
        poll(C_IRQ, 2);
        repeat (4) @(posedge clk_sys);
        chk("power off", 0, power_on);
        chk("motor zero", 0, motor_cmd);
        chk("line off", 0, link.line_on);
        chk("brake on", 1, hold_brake);
        chk("no extra reset", 1, reinits);
        bus(1'b1, C_IRQ, 32'h7);
        $display("test stop done");
        standstill <= 1'b0;
        bus(1'b1, C_CTRL, 32'h0101);
        poll(C_STAT, 3);
        fault_in <= 1'b1;
        poll(C_IRQ, 1);
        chk("fault free", 0, link.fault_free);
        chk("fault line", 0, link.line_on);
        chk("fault power", 0, power_on);
        chk("irq fault", 1, irq);
        fault_in <= 1'b0;
        bus(1'b1, C_IRQ, 32'h7);
        n = reinits;
        bus(1'b1, C_CTRL, 32'h0101);
        while (reinits == n) @(posedge clk_sys);
        repeat (BW + 10) @(posedge clk_sys);
        chk("fault reset", 2, reinits);
        bus(1'b1, C_CTRL, 32'h0101);
        poll(C_STAT, 3);
        chk("ok again", 1, link.fault_free);
        chk("power again", 1, power_on);
        $display("test fault done");
        tally_and_finish();
    end
endmodule : servo_drive_enable_sequencer_test
